// ### sercr_defines.vh
// Purpose: constants for the sink error report and crc injection block
// Assumes: verilog-2005, included by bare name
// Notes:   error vector layout is per-lane bits then fixed positions
// Summary of operation
// - a corrected single-bit memory error pulses vector bit lanes+3 for one cycle.
// - in continuous mode any rate-adaptation buffer overrun raises the overrun flag.
// - in burst mode the overrun flag is raised only when the overrun occurs inside a burst.
// - loss of lane alignment pulses vector bit lanes for one cycle.
// - after alignment loss the core reinitialises and realigns by itself.
// - coding-layer meta-frame errors assert the per-lane bits 0 to lanes-1.
// - each condition also sets its own bit in the receive error status.
// - the interrupt fires only for conditions whose enable bit is set.
// - a crc-32 mismatch on any lane's diagnostic word is detected and reported.
// - while injection is asserted, crc-32 is corrupted on every lane with injection enabled.
// - an uncorrectable double-bit memory error pulses vector bit lanes+4 for one cycle.
`ifndef SERCR_DEFINES_VH
`define SERCR_DEFINES_VH
// status bit positions
`define SERCR_ST_PCS      0
`define SERCR_ST_CRC      1
`define SERCR_ST_ALIGN    2
`define SERCR_ST_OVFL     3
`define SERCR_ST_ECC_COR  4
`define SERCR_ST_ECC_FAT  5
`define SERCR_ST_W        6
// error vector offsets above lane count
`define SERCR_EV_ALIGN    0
`define SERCR_EV_OVFL     2
`define SERCR_EV_ECC_COR  3
`define SERCR_EV_ECC_FAT  4
`define SERCR_EV_EXTRA    5
// realignment wait after loss, in cycles
`define SERCR_REALIGN_CYC 16'h0010
`define SERCR_CRC_MASK    32'h0000_0001
`endif

// ### sercr_crc_lane.v
// Purpose: per-lane crc-32 corruption on transmit, mismatch check on receive
// Assumes: crc values supplied by the coding layer each lane
// Notes:   flips bit 0 of the generated crc when injecting
`timescale 1ns/10ps
`include "sercr_defines.vh"
module sercr_crc_lane (
    input  wire        mclk,          // clock
    input  wire        rst_b,         // async reset, low
    input  wire        clk_en,        // freeze when low
    input  wire        inject,        // global injection request
    input  wire        lane_inj_en,   // lane config bit
    input  wire [31:0] tx_crc_in,     // generated crc
    input  wire        rx_dcw_valid,  // diagnostic word present
    input  wire [31:0] rx_crc_calc,   // computed crc
    input  wire [31:0] rx_crc_rcvd,   // received crc
    output reg  [31:0] tx_crc_q,      // crc sent on the lane
    output reg         crc_err_q      // one-cycle mismatch pulse
);
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_crc_q  <= 32'h0000_0000;
            crc_err_q <= 1'b0;
        end
        else if (clk_en)
        begin
            tx_crc_q <= (inject && lane_inj_en) ?
                        (tx_crc_in ^ `SERCR_CRC_MASK) : tx_crc_in;
            crc_err_q <= rx_dcw_valid &&
                         (rx_crc_calc != rx_crc_rcvd);
        end
    end
endmodule

// ### sercr_sink_err.v
// Purpose: sink error vector, sticky status, interrupt, crc injection
// Assumes: all inputs synchronous to mclk
// Notes:   status cleared by write-one-to-clear pulse vector
`timescale 1ns/10ps
`include "sercr_defines.vh"
module sercr_sink_err #(
    parameter LANES = 4
) (
    input  wire                        mclk,           // 20 MHz clock
    input  wire                        rst_b,          // async reset, low
    input  wire                        clk_en,         // freeze when low
    input  wire                        burst_mode,     // 1 burst, 0 continuous
    input  wire                        in_burst,       // burst crossing user side
    input  wire                        fifo_overflow,  // rate fifo overrun
    input  wire                        ecc_corrected,  // single-bit fixed
    input  wire                        ecc_fatal,      // double-bit found
    input  wire                        align_lost,     // alignment loss seen
    input  wire                        aligned,        // lanes aligned
    input  wire [LANES-1:0]            pcs_err,        // per-lane frame errors
    input  wire                        crc_inject,     // injection request
    input  wire [LANES-1:0]            lane_inj_en,    // per-lane config bit
    input  wire [32*LANES-1:0]         tx_crc_in,      // generated crcs
    input  wire [LANES-1:0]            rx_dcw_valid,   // diag word per lane
    input  wire [32*LANES-1:0]         rx_crc_calc,    // computed crcs
    input  wire [32*LANES-1:0]         rx_crc_rcvd,    // received crcs
    input  wire [`SERCR_ST_W-1:0]      status_clr,     // w1c pulses
    input  wire [`SERCR_ST_W-1:0]      irq_enable,     // per-condition enable
    output reg  [LANES+`SERCR_EV_EXTRA-1:0] error_rx_q, // error vector
    output reg  [`SERCR_ST_W-1:0]      status_q,       // sticky status
    output reg                         err_irq_q,      // interrupt level
    output reg                         realign_q,      // realign in progress
    output reg  [LANES-1:0]            crc_err_q,      // per-lane crc errors
    output wire [32*LANES-1:0]         tx_crc_out      // crc to each lane
);
    localparam EW = LANES + `SERCR_EV_EXTRA;
    // --------------------------------------------------------------
    // realign state machine
    // --------------------------------------------------------------
    localparam [1:0] S_RUN = 2'b01;
    localparam [1:0] S_REALIGN = 2'b10;

    reg  [1:0]             state_q;
    reg  [15:0]            wait_q;
    wire [LANES-1:0]       lane_crc;
    wire                   align_evt;
    wire                   ovfl_evt;
    wire [`SERCR_ST_W-1:0] evt;
    reg  [EW-1:0]          ev_d;

    // only a loss while running counts; repeats during realign are ignored
    assign align_evt = align_lost && (state_q == S_RUN);
    // burst mode masks overruns between bursts
    assign ovfl_evt = fifo_overflow &&
                      (!burst_mode || in_burst);

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q   <= S_RUN;
            wait_q    <= 16'h0000;
            realign_q <= 1'b0;
        end
        else if (clk_en)
        begin
            case (state_q)
                S_RUN:
                begin
                    if (align_evt)
                    begin
                        state_q   <= S_REALIGN;
                        wait_q    <= `SERCR_REALIGN_CYC;
                        realign_q <= 1'b1;
                    end
                end
                S_REALIGN:
                begin
                    if (wait_q != 16'h0000)
                        wait_q <= wait_q - 16'h0001;
                    else if (aligned)
                    begin
                        state_q   <= S_RUN;
                        realign_q <= 1'b0;
                    end
                end
                default:
                begin
                    state_q   <= S_RUN;
                    realign_q <= 1'b0;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // per-lane crc logic
    // --------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1)
        begin : g_lane
            sercr_crc_lane u_lane (
                .mclk         (mclk),
                .rst_b        (rst_b),
                .clk_en       (clk_en),
                .inject       (crc_inject),
                .lane_inj_en  (lane_inj_en[g]),
                .tx_crc_in    (tx_crc_in[32*g+31:32*g]),
                .rx_dcw_valid (rx_dcw_valid[g]),
                .rx_crc_calc  (rx_crc_calc[32*g+31:32*g]),
                .rx_crc_rcvd  (rx_crc_rcvd[32*g+31:32*g]),
                .tx_crc_q     (tx_crc_out[32*g+31:32*g]),
                .crc_err_q    (lane_crc[g])
            );
        end
    endgenerate

    // --------------------------------------------------------------
    // error vector, status, interrupt
    // --------------------------------------------------------------
    assign evt[`SERCR_ST_PCS]     = |pcs_err;
    assign evt[`SERCR_ST_CRC]     = |lane_crc;
    assign evt[`SERCR_ST_ALIGN]   = align_evt;
    assign evt[`SERCR_ST_OVFL]    = ovfl_evt;
    assign evt[`SERCR_ST_ECC_COR] = ecc_corrected;
    assign evt[`SERCR_ST_ECC_FAT] = ecc_fatal;

    always @*
    begin
        ev_d = {EW{1'b0}};
        ev_d[LANES-1:0] = pcs_err;
        ev_d[LANES+`SERCR_EV_ALIGN]   = align_evt;
        ev_d[LANES+`SERCR_EV_OVFL]    = ovfl_evt;
        ev_d[LANES+`SERCR_EV_ECC_COR] = ecc_corrected;
        ev_d[LANES+`SERCR_EV_ECC_FAT] = ecc_fatal;
    end

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            error_rx_q <= {EW{1'b0}};
            status_q   <= {`SERCR_ST_W{1'b0}};
            err_irq_q  <= 1'b0;
            crc_err_q  <= {LANES{1'b0}};
        end
        else if (clk_en)
        begin
            error_rx_q <= ev_d;
            crc_err_q  <= lane_crc;
            // set wins over a clear in the same cycle
            status_q <= (status_q & ~status_clr) | evt;
            err_irq_q <= |(((status_q & ~status_clr) | evt)
                           & irq_enable);
        end
    end
endmodule

// ### sercr_monitor.sv
// Purpose: port checks for the sink error block
// Assumes: clk_en high whenever events arrive
// Notes:   bound to every instance of the block
`timescale 1ns/10ps
module sercr_monitor #(parameter LANES = 4) (
    input wire mclk, rst_b, clk_en, burst_mode, in_burst, // controls
    input wire fifo_overflow, ecc_corrected, ecc_fatal, align_lost, // events
    input wire [LANES-1:0] pcs_err, lane_inj_en, rx_dcw_valid, // lanes
    input wire [LANES-1:0] crc_err_q, // crc errors
    input wire crc_inject, err_irq_q, realign_q, // levels
    input wire [32*LANES-1:0] tx_crc_in, rx_crc_calc, rx_crc_rcvd, // crcs
    input wire [32*LANES-1:0] tx_crc_out, // crc sent
    input wire [5:0] status_clr, irq_enable, status_q, // status
    input wire [LANES+4:0] error_rx_q // error vector
);
default clocking cb @(posedge mclk); endclocking
default disable iff (!rst_b);
property p_cor; clk_en && ecc_corrected |=> error_rx_q[LANES+3]; endproperty
a_cor: assert property (p_cor) else $error("corrected flag");
property p_fat; clk_en && ecc_fatal |=> error_rx_q[LANES+4]; endproperty
a_fat: assert property (p_fat) else $error("fatal flag");
property p_ovf;
    clk_en && fifo_overflow && !burst_mode |=> error_rx_q[LANES+2];
endproperty
a_ovf: assert property (p_ovf) else $error("overrun flag");
property p_bst;
    error_rx_q[LANES+2] |-> $past(fifo_overflow && (!burst_mode || in_burst));
endproperty
a_bst: assert property (p_bst) else $error("overrun outside burst");
property p_aln;
    clk_en && align_lost && !realign_q |=> error_rx_q[LANES] && realign_q;
endproperty
a_aln: assert property (p_aln) else $error("align loss");
property p_one; error_rx_q[LANES] |=> !clk_en || !error_rx_q[LANES]; endproperty
a_one: assert property (p_one) else $error("align pulse long");
property p_pcs;
    clk_en && |pcs_err |=> error_rx_q[LANES-1:0] == $past(pcs_err);
endproperty
a_pcs: assert property (p_pcs) else $error("lane errors");
property p_stk;
    clk_en |=> ($past(status_q) & ~$past(status_clr) & ~status_q) == 6'h00;
endproperty
a_stk: assert property (p_stk) else $error("status lost");
property p_irq;
    err_irq_q |-> |($past(irq_enable) & (status_q | $past(status_q)));
endproperty
a_irq: assert property (p_irq) else $error("irq unmasked");
property p_crc; clk_en && rx_dcw_valid[0] &&
    rx_crc_calc[31:0] != rx_crc_rcvd[31:0] |-> ##2 crc_err_q[0]; endproperty
a_crc: assert property (p_crc) else $error("crc mismatch");
property p_inj; $past(clk_en) && $past(rst_b) |-> tx_crc_out[31:0] ==
    ($past(tx_crc_in[31:0]) ^ $past(crc_inject && lane_inj_en[0])); endproperty
a_inj: assert property (p_inj) else $error("crc inject");
endmodule
bind sercr_sink_err sercr_monitor #(.LANES(LANES)) sercr_monitor_inst (.*);

// ### sercr_user_model.sv
// Purpose: user side that sets a lane config bit and injects
// Assumes: link_up means both links up with traffic flowing
// Notes:   lane 1 stays disabled as a control lane
`timescale 1ns/10ps
module sercr_user_model (
    input  wire       mclk,        // clock
    input  wire       rst_b,       // async reset, low
    input  wire       link_up,     // both links up
    input  wire       go,          // start injection
    output reg  [1:0] lane_inj_en, // config bits
    output reg        crc_inject   // injection request
);
    // payload checks left to the data path
    always @(posedge mclk or negedge rst_b)
        if (!rst_b)
            {lane_inj_en, crc_inject} <= 3'h0;
        else
            {lane_inj_en, crc_inject} <= {1'b0, go,
                go && link_up && lane_inj_en[0]};
endmodule

// ### sercr_sink_err_test.sv
// Purpose: scenario bench for the sink error block
// Assumes: two lanes, clk_en high except for one cycle in sc_pcs
// Notes:   each scenario judges its own results
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks = num_checks + 1; if ((a) !== (b)) begin \
    mismatches = mismatches + 1; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module sercr_sink_err_test;
    localparam L = 2;
    reg mclk = 0, rst_b = 0, clk_en = 1, burst_mode = 0, in_burst = 0;
    reg fifo_overflow = 0, ecc_corrected = 0, ecc_fatal = 0, align_lost = 0;
    reg aligned = 0, link_up = 0, go = 0;
    reg [L-1:0] pcs_err = 0, rx_dcw_valid = 0;
    reg [32*L-1:0] tx_crc_in = 0, rx_crc_calc = 0, rx_crc_rcvd = 0;
    reg [5:0] status_clr = 0, irq_enable = 0;
    wire [L+4:0] error_rx_q;
    wire [5:0] status_q;
    wire err_irq_q, realign_q, crc_inject;
    wire [L-1:0] crc_err_q, lane_inj_en;
    wire [32*L-1:0] tx_crc_out;
    integer mismatches = 0, num_checks = 0, i;
    sercr_sink_err #(.LANES(L)) sercr_sink_err_inst (.*);
    sercr_user_model sercr_user_model_inst (.*);
    initial forever #25 mclk = ~mclk;
    task report_and_stop;
        if (mismatches == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task bound(input integer n);
        if (i == n) begin mismatches = mismatches + 1; report_and_stop; end
    endtask
    task sc_events;
        @(posedge mclk) {ecc_fatal, ecc_corrected, fifo_overflow} <= 3'h7;
        @(posedge mclk) {ecc_fatal, ecc_corrected, fifo_overflow} <= 3'h0;
        #1 `CHK(error_rx_q[L+4:L+1], 4'hE)
        `CHK(status_q[5:3], 3'h7)
        @(posedge mclk) #1 `CHK(error_rx_q[L+4:L+2], 3'h0)
        `CHK(status_q[5:3], 3'h7)
    endtask
    task sc_burst;
        @(posedge mclk) {burst_mode, fifo_overflow} <= 2'h3;
        @(posedge mclk) in_burst <= 1'b1;
        #1 `CHK(error_rx_q[L+2], 1'b0)
        @(posedge mclk) {burst_mode, in_burst, fifo_overflow} <= 3'h0;
        #1 `CHK(error_rx_q[L+2], 1'b1)
    endtask
    task sc_align;
        @(posedge mclk) align_lost <= 1'b1;
        @(posedge mclk) #1 `CHK({error_rx_q[L], realign_q}, 2'h3)
        @(posedge mclk) {align_lost, aligned} <= 2'h1;
        #1 `CHK(error_rx_q[L], 1'b0)
        for (i = 0; i < 40 && realign_q === 1'b1; i = i + 1)
            @(posedge mclk) #1;
        bound(40);
        `CHK(i, 16)
    endtask
    task sc_pcs;
        @(posedge mclk) pcs_err <= 2'h2;
        @(posedge mclk) pcs_err <= 2'h0;
        #1 `CHK({error_rx_q[L-1:0], status_q[0]}, 3'h5)
        @(posedge mclk) {clk_en, pcs_err} <= 3'h1;
        @(posedge mclk) {clk_en, pcs_err} <= 3'h4;
        #1 `CHK(error_rx_q[L-1:0], 2'h0)
    endtask
    task sc_irq;
        @(posedge mclk) #1 `CHK(err_irq_q, 1'b0)
        @(posedge mclk) irq_enable <= 6'h10;
        repeat (2) @(posedge mclk);
        #1 `CHK(err_irq_q, 1'b1)
        @(posedge mclk) status_clr <= 6'h3F;
        @(posedge mclk) status_clr <= 6'h00;
        repeat (2) @(posedge mclk);
        #1 `CHK({status_q, err_irq_q}, 7'h00)
    endtask
    task sc_crc;
        @(posedge mclk) {link_up, go} <= 2'h3;
        tx_crc_in <= 64'h1234_5678_9ABC_DEF0;
        for (i = 0; i < 20 && crc_inject !== 1'b1; i = i + 1)
            @(posedge mclk) #1;
        bound(20);
        repeat (2) @(posedge mclk);
        #1 `CHK(tx_crc_out, 64'h1234_5678_9ABC_DEF1)
        @(posedge mclk) {rx_dcw_valid, rx_crc_rcvd} <= {2'h1, 64'h1};
        @(posedge mclk) rx_dcw_valid <= 2'h0;
        @(posedge mclk) #1 `CHK({crc_err_q, status_q[1]}, 3'h3)
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        sc_events;
        sc_burst;
        sc_align;
        sc_pcs;
        sc_irq;
        sc_crc;
        report_and_stop;
    end
endmodule
